// ### src/sdc_defines.vh
// Constants for the stereo DAC control register block
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH

// ----------------------------------------------------------------
// Serial control word layout
// ----------------------------------------------------------------
`define SDC_WORD_BITS      16
`define SDC_ADDR_HI        11
`define SDC_ADDR_LO        9
`define SDC_ADDR_LEFT      3'h0
`define SDC_ADDR_RIGHT     3'h1
`define SDC_ADDR_OUTPUT    3'h2
`define SDC_ADDR_FORMAT    3'h3
`define SDC_ADDR_ROUTING   3'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDC_GAIN_HI        7
`define SDC_LOAD_BIT       8
`define SDC_SILENCE_BIT    0
`define SDC_DEEMPH_BIT     1
`define SDC_ZERO_BIT       2
`define SDC_WLEN_HI        4
`define SDC_WLEN_LO        3
`define SDC_KEY_HI         8
`define SDC_KEY_LO         5
`define SDC_KEY_VALUE      4'hF
`define SDC_I2S_BIT        0
`define SDC_FRAME_POL_BIT  1
`define SDC_SHARED_BIT     2
`define SDC_ROLLOFF_BIT    3
`define SDC_INVERT_BIT     4
`define SDC_RATE_HI        7
`define SDC_RATE_LO        6
`define SDC_ZRUN_BIT       8
`define SDC_ROUTE_HI       5
`define SDC_ROUTE_LO       4
`define SDC_GUARD_OFF_BIT  6

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define SDC_GAIN_RESET     8'hFF
`define SDC_GAIN_MUTE      8'h00
`define SDC_ROUTE_STEREO   2'h0
`define SDC_ROUTE_MONO_L   2'h1
`define SDC_ROUTE_SWAP     2'h2
`define SDC_ROUTE_MONO_R   2'h3
`define SDC_MAP_STEREO     8'hD8
`define SDC_MAP_SWAP       8'h8D
`define SDC_MAP_MONO_L     8'h28
`define SDC_MAP_MONO_R     8'hD7
`define SDC_LEN_16         2'h0
`define SDC_LEN_20         2'h1
`define SDC_LEN_24         2'h2
`define SDC_JUST_RIGHT     2'h0
`define SDC_JUST_LEFT      2'h1
`define SDC_JUST_I2S       2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SDC_CLK_MHZ        250
`define SDC_LOSS_US        100
`define SDC_RAMP_SAMPLES   128
`define SDC_RAMP_LAST      7'h7F

`endif

// ### src/sdc_ctrl_regs.v
// Control registers, gain ramp and output routing of a stereo DAC
// Notes on behaviour
// - Code X gives 0.5*(X-255) dB, zero mutes
// - Load strobe clear stores code only
// - Applied gain updates only on load strobe
// - Shared select applies left code to both
// - Soft silence ramps to zero and back
// - One half-dB step per 128 samples
// - Deemphasis bit enables deemphasis
// - Zero force bit drives output to zero
// - Format and length bits select input format
// - Frame polarity bit swaps left/right level
// - Roll-off bit selects sharp or slow
// - Invert bit reverses analogue polarity
// - Rate bits select deemphasis response
// - Zero-run silence enable bit
// - Routing register locked until key written
// - Routing bits pick stereo, swap or mono
// - Left mono drives all outputs from left
// - Right mono drives all outputs from right
// - Stopped system clock mutes unless guard off
// - Addresses 0-3 main, 6 locked register
// - Gains reset to FF, routing outputs to stereo map D8, all else zero
`timescale 1ns/1ps
`include "sdc_defines.vh"

module sdc_ctrl_regs #(
	parameter LOSS_CYCLES = `SDC_LOSS_US * `SDC_CLK_MHZ,	// Clock loss timeout
	parameter LOSS_W      = 16				// Timeout counter width
) (
	input  wire       mclk_i,			// 250 MHz core clock
	input  wire       rst_i,			// Synchronous reset, high
	input  wire       serial_ctrl_data_pin_i,	// Serial data pin
	input  wire       serial_ctrl_clock_pin_i,	// Serial shift clock pin
	input  wire       serial_ctrl_latch_pin_i,	// Serial latch pin
	input  wire       write_guard_pin_i,		// Must be low to write
	input  wire       frame_clock_in_i,		// Frame clock pin
	input  wire       sys_clock_pin_i,		// System clock being watched
	output wire [7:0] left_gain_o,			// Present left gain code
	output wire [7:0] right_gain_o,			// Present right gain code
	output reg        left_mute_o,			// Left at minus infinity
	output reg        right_mute_o,			// Right at minus infinity
	output reg        deemphasis_enable_o,		// Deemphasis on
	output reg  [1:0] deemph_rate_sel_o,		// 0 none,1 48k,2 44.1k,3 32k
	output reg        output_zero_force_o,		// Output at bipolar zero
	output reg  [1:0] data_len_o,			// 0:16 1:20 2:24 bit
	output reg  [1:0] data_just_o,			// 0 right,1 left,2 I2S
	output reg        left_slot_o,			// Frame clock marks left now
	output reg        slow_rolloff_sel_o,		// 1 slow, 0 sharp
	output reg        output_invert_o,		// Analogue polarity reversed
	output reg        zero_run_silence_en_o,	// Zero-run muting enabled
	output reg  [1:0] out_left_pos_o,		// {invert, take right}
	output reg  [1:0] out_left_neg_o,		// {invert, take right}
	output reg  [1:0] out_right_pos_o,		// {invert, take right}
	output reg  [1:0] out_right_neg_o,		// {invert, take right}
	output reg        analog_mute_o,		// Clock lost analogue mute
	output reg        filter_reset_o		// Clock lost filter reset
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	reg  [5:0] sync1_r;		// First stage, read by second only
	reg  [5:0] sync2_r;		// Second stage, safe for logic
	reg  [5:0] sync3_r;		// Delayed copy for edge detection
	wire       sdata  = sync2_r[0];
	wire       sclk_rise  = sync2_r[1] & ~sync3_r[1];
	wire       latch_rise = sync2_r[2] & ~sync3_r[2];
	wire       guard  = sync2_r[3];
	wire       frame_rise = sync2_r[4] & ~sync3_r[4];
	wire       sys_edge   = sync2_r[5] ^ sync3_r[5];

	// Two flops on every pin before any logic looks at it
	always @(posedge mclk_i) begin
		if (rst_i) begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
			sync3_r <= 6'h00;
		end else begin
			sync1_r <= {sys_clock_pin_i, frame_clock_in_i, write_guard_pin_i,
				serial_ctrl_latch_pin_i, serial_ctrl_clock_pin_i,
				serial_ctrl_data_pin_i};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// ----------------------------------------------------------------
	// Serial shifter and register file
	// ----------------------------------------------------------------
	reg  [15:0] shift_r;		// Incoming word, MSB first
	reg  [7:0]  left_code_r;	// Stored left code
	reg  [7:0]  right_code_r;	// Stored right code
	reg  [7:0]  left_tgt_r;		// Applied left code
	reg  [7:0]  right_tgt_r;	// Applied right code
	reg  [4:0]  out_ctl_r;		// Silence, deemph, zero, length
	reg  [8:0]  fmt_ctl_r;		// Format register bits
	reg         unlocked_r;		// Routing register reachable
	reg  [1:0]  route_r;		// Routing mode
	reg         guard_off_r;	// Clock loss guard disabled

	wire [2:0]  addr  = shift_r[`SDC_ADDR_HI:`SDC_ADDR_LO];
	wire [7:0]  code  = shift_r[`SDC_GAIN_HI:0];
	wire        load  = shift_r[`SDC_LOAD_BIT];
	wire        commit = latch_rise & ~guard;

	// Shift on serial clock, act on latch; guard high blocks both
	always @(posedge mclk_i) begin
		if (rst_i) begin
			shift_r      <= 16'h0000;
			left_code_r  <= `SDC_GAIN_RESET;
			right_code_r <= `SDC_GAIN_RESET;
			left_tgt_r   <= `SDC_GAIN_RESET;
			right_tgt_r  <= `SDC_GAIN_RESET;
			out_ctl_r    <= 5'h00;
			fmt_ctl_r    <= 9'h000;
			unlocked_r   <= 1'b0;
			route_r      <= `SDC_ROUTE_STEREO;
			guard_off_r  <= 1'b0;
		end else begin
			if (sclk_rise && !guard) begin
				shift_r <= {shift_r[14:0], sdata};
			end
			if (commit) begin
				case (addr)
				`SDC_ADDR_LEFT: begin
					left_code_r <= code;
					if (load) begin
						left_tgt_r  <= code;
						right_tgt_r <= right_code_r;
					end
				end
				`SDC_ADDR_RIGHT: begin
					right_code_r <= code;
					if (load) begin
						right_tgt_r <= code;
						left_tgt_r  <= left_code_r;
					end
				end
				`SDC_ADDR_OUTPUT: begin
					out_ctl_r <= shift_r[`SDC_WLEN_HI:0];
					// Key pattern opens the routing register
					if (shift_r[`SDC_KEY_HI:`SDC_KEY_LO] == `SDC_KEY_VALUE) begin
						unlocked_r <= 1'b1;
					end
				end
				`SDC_ADDR_FORMAT: begin
					fmt_ctl_r <= shift_r[`SDC_ZRUN_BIT:0];
				end
				`SDC_ADDR_ROUTING: begin
					// Ignored while still locked
					if (unlocked_r) begin
						route_r     <= shift_r[`SDC_ROUTE_HI:`SDC_ROUTE_LO];
						guard_off_r <= shift_r[`SDC_GUARD_OFF_BIT];
					end
				end
				default: begin
					shift_r <= shift_r;	// Unmapped address: no effect
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Soft ramp timing
	// ----------------------------------------------------------------
	reg  [6:0] smp_cnt_r;		// Sample periods since last step
	wire       step = frame_rise && (smp_cnt_r == `SDC_RAMP_LAST);

	// One frame clock rise is one sample period
	always @(posedge mclk_i) begin
		if (rst_i) begin
			smp_cnt_r <= 7'h00;
		end else if (frame_rise) begin
			smp_cnt_r <= smp_cnt_r + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Per channel gain ramp
	// ----------------------------------------------------------------
	reg  [15:0] level_r;		// {right, left} present gain codes
	wire [15:0] aim;		// Ramp target per channel
	wire        silence = out_ctl_r[`SDC_SILENCE_BIT];
	wire [7:0]  right_eff = fmt_ctl_r[`SDC_SHARED_BIT] ? left_tgt_r : right_tgt_r;
	assign aim = silence ? {`SDC_GAIN_MUTE, `SDC_GAIN_MUTE} :
		{right_eff, left_tgt_r};

	wire [15:0] level_nxt;		// Next gain codes, one step at most

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ramp
			wire [7:0] cur = level_r[ch*8 +: 8];
			wire [7:0] tgt = aim[ch*8 +: 8];
			// A changed target mid-ramp is simply the next aim
			assign level_nxt[ch*8 +: 8] = (!step || cur == tgt) ? cur :
				(cur < tgt) ? cur + 8'h01 :
				cur - 8'h01;
		end
	endgenerate

	// One process owns both channels, so each flop has a single driver
	always @(posedge mclk_i) begin
		if (rst_i) begin
			level_r <= {`SDC_GAIN_RESET, `SDC_GAIN_RESET};
		end else begin
			level_r <= level_nxt;
		end
	end

	// Code meaning is 0.5*(code-255) dB; downstream maps it
	assign left_gain_o  = level_r[7:0];
	assign right_gain_o = level_r[15:8];

	// ----------------------------------------------------------------
	// Clock loss watchdog
	// ----------------------------------------------------------------
	reg  [LOSS_W-1:0] idle_r;	// Core cycles since last edge
	wire lost = (idle_r >= LOSS_CYCLES[LOSS_W-1:0]);

	// Counting saturates, so a long stop cannot wrap to looking alive
	always @(posedge mclk_i) begin
		if (rst_i || sys_edge) begin
			idle_r <= {LOSS_W{1'b0}};
		end else if (!lost) begin
			idle_r <= idle_r + {{(LOSS_W-1){1'b0}}, 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// Decoded control outputs
	// ----------------------------------------------------------------
	reg [1:0] len_nxt;	// Decoded word length
	reg [1:0] just_nxt;	// Decoded justification
	reg [7:0] route_nxt;	// {rn, rp, ln, lp} each {inv, right}

	// Format select table and routing table
	always @* begin
		case ({fmt_ctl_r[`SDC_I2S_BIT], out_ctl_r[`SDC_WLEN_HI:`SDC_WLEN_LO]})
		3'h0: begin len_nxt = `SDC_LEN_16; just_nxt = `SDC_JUST_RIGHT; end
		3'h1: begin len_nxt = `SDC_LEN_20; just_nxt = `SDC_JUST_RIGHT; end
		3'h2: begin len_nxt = `SDC_LEN_24; just_nxt = `SDC_JUST_RIGHT; end
		3'h3: begin len_nxt = `SDC_LEN_24; just_nxt = `SDC_JUST_LEFT;  end
		3'h4: begin len_nxt = `SDC_LEN_16; just_nxt = `SDC_JUST_I2S;   end
		3'h5: begin len_nxt = `SDC_LEN_24; just_nxt = `SDC_JUST_I2S;   end
		3'h6: begin len_nxt = `SDC_LEN_20; just_nxt = `SDC_JUST_I2S;   end
		default: begin len_nxt = `SDC_LEN_20; just_nxt = `SDC_JUST_LEFT; end
		endcase
		// Each lane is {invert, take right}; stereo keeps left on the
		// left pair, swap crosses the pairs, mono drives all four
		case (route_r)
		`SDC_ROUTE_SWAP:   route_nxt = `SDC_MAP_SWAP;
		`SDC_ROUTE_MONO_L: route_nxt = `SDC_MAP_MONO_L;
		`SDC_ROUTE_MONO_R: route_nxt = `SDC_MAP_MONO_R;
		default:           route_nxt = `SDC_MAP_STEREO;
		endcase
	end

	// Every output leaves from a flop
	always @(posedge mclk_i) begin
		if (rst_i) begin
			left_mute_o           <= 1'b0;
			right_mute_o          <= 1'b0;
			deemphasis_enable_o   <= 1'b0;
			deemph_rate_sel_o     <= 2'h0;
			output_zero_force_o   <= 1'b0;
			data_len_o            <= `SDC_LEN_16;
			data_just_o           <= `SDC_JUST_RIGHT;
			left_slot_o           <= 1'b0;
			slow_rolloff_sel_o    <= 1'b0;
			output_invert_o       <= 1'b0;
			zero_run_silence_en_o <= 1'b0;
			{out_right_neg_o, out_right_pos_o,
				out_left_neg_o, out_left_pos_o} <= `SDC_MAP_STEREO;
			analog_mute_o         <= 1'b0;
			filter_reset_o        <= 1'b0;
		end else begin
			left_mute_o           <= (level_r[7:0] == `SDC_GAIN_MUTE);
			right_mute_o          <= (level_r[15:8] == `SDC_GAIN_MUTE);
			deemphasis_enable_o   <= out_ctl_r[`SDC_DEEMPH_BIT];
			deemph_rate_sel_o     <= fmt_ctl_r[`SDC_RATE_HI:`SDC_RATE_LO];
			output_zero_force_o   <= out_ctl_r[`SDC_ZERO_BIT];
			data_len_o            <= len_nxt;
			data_just_o           <= just_nxt;
			left_slot_o           <= sync2_r[4] ^ fmt_ctl_r[`SDC_FRAME_POL_BIT];
			slow_rolloff_sel_o    <= fmt_ctl_r[`SDC_ROLLOFF_BIT];
			output_invert_o       <= fmt_ctl_r[`SDC_INVERT_BIT];
			zero_run_silence_en_o <= fmt_ctl_r[`SDC_ZRUN_BIT];
			out_left_pos_o        <= route_nxt[1:0];
			out_left_neg_o        <= route_nxt[3:2];
			out_right_pos_o       <= route_nxt[5:4];
			out_right_neg_o       <= route_nxt[7:6];
			analog_mute_o         <= lost & ~guard_off_r;
			filter_reset_o        <= lost & ~guard_off_r;
		end
	end

endmodule // sdc_ctrl_regs

// ### tb/sdc_host_model.sv
// Host model that writes control words over the three-wire serial port
`timescale 1ns/1ps
module sdc_host_model (
	input  wire mclk_i,	// Core clock, pins move just after its rising edge
	output reg  data_o,	// Serial data, MSB first
	output reg  sclk_o,	// Shift clock, stands low outside words
	output reg  latch_o,	// Latch line, rising edge commits
	output reg  guard_o	// Write guard, high while idle
);
	initial begin
		data_o = 1'b0;
		sclk_o = 1'b0;
		latch_o = 1'b0;
		guard_o = 1'b1;
	end
	// Each pin level stands 4 cycles, above the 3-cycle minimum of the synchronisers
	task automatic write_word(input [15:0] w, input blk);
		integer i;
		begin
			@(posedge mclk_i);
			guard_o <= blk;
			for (i = 15; i >= 0; i = i - 1) begin
				data_o <= w[i];
				repeat (4) @(posedge mclk_i);
				sclk_o <= 1'b1;
				repeat (4) @(posedge mclk_i);
				sclk_o <= 1'b0;
			end
			data_o <= ~w[0];	// Stale data is not left on the line
			latch_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
			latch_o <= 1'b0;
			repeat (4) @(posedge mclk_i);
			guard_o <= 1'b1;
		end
	endtask
endmodule // sdc_host_model

// ### tb/sdc_ctrl_regs_properties.sv
// Port assertions for the stereo DAC control register block
`timescale 1ns/1ps
module sdc_ctrl_regs_props #(
	parameter LOSS_CYCLES = 25000,	// Clock loss timeout
	parameter LOSS_W      = 16	// Timeout counter width
) (
	input wire       mclk_i,
	input wire       rst_i,
	input wire       write_guard_pin_i,
	input wire       sys_clock_pin_i,
	input wire [7:0] left_gain_o,
	input wire [7:0] right_gain_o,
	input wire       deemphasis_enable_o,
	input wire       output_zero_force_o,
	input wire [1:0] data_len_o,
	input wire [1:0] data_just_o,
	input wire [1:0] out_left_pos_o,
	input wire [1:0] out_left_neg_o,
	input wire [1:0] out_right_pos_o,
	input wire [1:0] out_right_neg_o,
	input wire       analog_mute_o,
	input wire       filter_reset_o
);
	reg [15:0] idle_r;	// Cycles since the watched clock last moved
	reg        sys_q_r;	// Previous pin level
	// Idle counter saturates so a long stop never wraps to zero
	always @(posedge mclk_i) begin
		sys_q_r <= sys_clock_pin_i;
		if (rst_i || sys_clock_pin_i != sys_q_r)
			idle_r <= 16'h0000;
		else if (idle_r != 16'hFFFF)
			idle_r <= idle_r + 16'h0001;
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	property p_route_legal;
		{out_right_neg_o, out_right_pos_o, out_left_neg_o, out_left_pos_o}
			inside {8'hD8, 8'h8D, 8'h28, 8'hD7};
	endproperty
	a_route_legal: assert property (p_route_legal) else $error("routing code illegal");
	property p_left_pair;
		out_left_neg_o == {~out_left_pos_o[1], out_left_pos_o[0]};
	endproperty
	a_left_pair: assert property (p_left_pair) else $error("left pair mismatch");
	property p_right_pair;
		out_right_pos_o == {~out_right_neg_o[1], out_right_neg_o[0]};
	endproperty
	a_right_pair: assert property (p_right_pair) else $error("right pair mismatch");
	property p_step_size;
		left_gain_o != $past(left_gain_o) |-> (left_gain_o == $past(left_gain_o) + 8'h01)
			|| (left_gain_o == $past(left_gain_o) - 8'h01);
	endproperty
	a_step_size: assert property (p_step_size) else $error("gain jumped");
	property p_step_gap;
		$changed(right_gain_o) |=> $stable(right_gain_o) [*8];
	endproperty
	a_step_gap: assert property (p_step_gap) else $error("gain steps too close");
	property p_loss_same;
		analog_mute_o == filter_reset_o;
	endproperty
	a_loss_same: assert property (p_loss_same) else $error("mute and reset differ");
	property p_loss_late;
		$rose(analog_mute_o) |-> idle_r >= LOSS_CYCLES - 4;
	endproperty
	a_loss_late: assert property (p_loss_late) else $error("clock loss seen early");
	property p_loss_clear;
		analog_mute_o && idle_r == 16'h0000 |-> ##[1:6] !analog_mute_o;
	endproperty
	a_loss_clear: assert property (p_loss_clear) else $error("mute held after clock");
	property p_guard_quiet;
		write_guard_pin_i [*8] |-> $stable({deemphasis_enable_o, output_zero_force_o,
			data_len_o, data_just_o});
	endproperty
	a_guard_quiet: assert property (p_guard_quiet) else $error("write while guarded");
endmodule // sdc_ctrl_regs_props
bind sdc_ctrl_regs sdc_ctrl_regs_props #(.LOSS_CYCLES(LOSS_CYCLES), .LOSS_W(LOSS_W)) u_props (
	.mclk_i(mclk_i), .rst_i(rst_i), .write_guard_pin_i(write_guard_pin_i),
	.sys_clock_pin_i(sys_clock_pin_i), .left_gain_o(left_gain_o), .right_gain_o(right_gain_o),
	.deemphasis_enable_o(deemphasis_enable_o), .output_zero_force_o(output_zero_force_o),
	.data_len_o(data_len_o), .data_just_o(data_just_o), .out_left_pos_o(out_left_pos_o),
	.out_left_neg_o(out_left_neg_o), .out_right_pos_o(out_right_pos_o),
	.out_right_neg_o(out_right_neg_o), .analog_mute_o(analog_mute_o),
	.filter_reset_o(filter_reset_o));

// ### tb/tb_sdc_ctrl_regs.sv
// Self-checking testbench of the stereo DAC control register block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked = checked + 1; if ((s) !== (e)) begin err_count = err_count + 1; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_sdc_ctrl_regs;
	localparam [31:0] FMT_TBL = 32'h56A29840;	// {len, just} by {i2s, iw}
	localparam [31:0] ROUTE_TBL = 32'hD78D28D8;	// {RN, RP, LN, LP} by mode
	reg        mclk_i, rst_i, frame_r, sys_r, frame_run, sys_run;
	integer    err_count, checked, i, fcnt, nfr;
	reg [31:0] v;	// Random draw
	reg [7:0]  g;	// Gain sample
	wire       sd, sc, sl, sg, lm, rm, deemphasis_enable, zf, slot, slow, inv, zrun, amute, frst;
	wire [7:0] lg, rg;
	wire [1:0] rate, len, just, lp, ln, rp, rn;
	sdc_host_model host (.mclk_i(mclk_i), .data_o(sd), .sclk_o(sc), .latch_o(sl), .guard_o(sg));
	sdc_ctrl_regs #(.LOSS_CYCLES(50)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.serial_ctrl_data_pin_i(sd), .serial_ctrl_clock_pin_i(sc), .serial_ctrl_latch_pin_i(sl),
		.write_guard_pin_i(sg), .frame_clock_in_i(frame_r), .sys_clock_pin_i(sys_r),
		.left_gain_o(lg), .right_gain_o(rg), .left_mute_o(lm), .right_mute_o(rm),
		.deemphasis_enable_o(deemphasis_enable), .deemph_rate_sel_o(rate), .output_zero_force_o(zf),
		.data_len_o(len), .data_just_o(just), .left_slot_o(slot), .slow_rolloff_sel_o(slow),
		.output_invert_o(inv), .zero_run_silence_en_o(zrun), .out_left_pos_o(lp),
		.out_left_neg_o(ln), .out_right_pos_o(rp), .out_right_neg_o(rn),
		.analog_mute_o(amute), .filter_reset_o(frst));
	// Expected byte {RN, RP, LN, LP} for a routing mode
	function [7:0] route_exp(input [1:0] m);
		route_exp = ROUTE_TBL[m*8 +: 8];
	endfunction
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	// Frame clock: 3 cycles a half, left half first; watched clock toggles every cycle
	always @(posedge mclk_i) begin
		fcnt <= (fcnt == 2) ? 0 : fcnt + 1;
		if (frame_run && fcnt == 2)
			frame_r <= ~frame_r;
		if (frame_run && fcnt == 2 && !frame_r)
			nfr <= nfr + 1;
		if (sys_run)
			sys_r <= ~sys_r;
	end
	task automatic wr(input [15:0] w, input blk);
		begin
			host.write_word(w, blk);
			repeat (8) @(posedge mclk_i);
			#1;
		end
	endtask
	task automatic frames(input integer n);
		integer t;
		begin
			t = nfr + n;
			while (nfr < t)
				@(posedge mclk_i);
			#1;
		end
	endtask
	task end_of_test;
		begin
			if (err_count == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Watchdog, about four times the expected run
	initial begin
		repeat (60000) @(posedge mclk_i);
		err_count = err_count + 1;
		end_of_test;
	end
	initial begin
		{rst_i, frame_r, sys_r, frame_run, sys_run} = 5'h11;
		{err_count, checked, fcnt, nfr} = 0;
		v = $urandom(32'hD28F);
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		#1;
		`CHK("gains", 16'hFFFF, {lg, rg})
		`CHK("ctrl", 15'h0000, {lm, rm, deemphasis_enable, rate, zf, len, just, slow, inv, zrun, amute, frst})
		`CHK("route", 8'hD8, {rn, rp, ln, lp})
		// Every input format, random side fields; reserved key bits kept clear
		for (i = 0; i < 8; i = i + 1) begin
			v = $urandom;
			wr({4'h0, 3'h2, 4'h0, i[1:0], v[2:1], 1'b0}, 1'b0);
			wr({4'h0, 3'h3, v[8:6], 1'b0, v[4:3], 1'b0, v[1], i[2]}, 1'b0);
			`CHK("fmt", FMT_TBL[i*4 +: 4], {len, just})
			`CHK("dem_zf", v[2:1], {zf, deemphasis_enable})
			`CHK("reg3", {v[8:6], v[4:3]}, {zrun, rate, inv, slow})
			`CHK("slot_lo", v[1], slot)
		end
		@(posedge mclk_i);
		frame_r <= 1'b1;
		wr({4'h0, 3'h2, 6'h0, ~v[2:1], 1'b0}, 1'b1);
		`CHK("slot_hi", ~v[1], slot)
		`CHK("guarded", v[2:1], {zf, deemphasis_enable})
		wr(16'h0C10, 1'b0);
		`CHK("locked", 8'hD8, {rn, rp, ln, lp})
		wr(16'h05E0, 1'b0);
		for (i = 0; i < 4; i = i + 1) begin
			wr({4'h0, 3'h6, 3'h0, i[1:0], 4'h0}, 1'b0);
			`CHK("routing", route_exp(i[1:0]), {rn, rp, ln, lp})
		end
		// Clock stop with the guard on, then with it off
		for (i = 0; i < 2; i = i + 1) begin
			wr({4'h0, 3'h6, 2'h0, i[0], 6'h0}, 1'b0);
			sys_run <= 1'b0;
			repeat (80) @(posedge mclk_i);
			#1;
			`CHK("loss", {2{~i[0]}}, {amute, frst})
			@(posedge mclk_i);
			sys_run <= 1'b1;
			repeat (10) @(posedge mclk_i);
			#1;
			`CHK("alive", 2'b00, {amute, frst})
		end
		@(posedge mclk_i);
		frame_run <= 1'b1;
		wr(16'h00FD, 1'b0);
		frames(300);
		`CHK("stored", 16'hFFFF, {lg, rg})
		wr(16'h03FE, 1'b0);
		frames(400);
		`CHK("loaded", 16'hFDFE, {lg, rg})
		wr(16'h0604, 1'b0);
		frames(300);
		`CHK("shared", 8'hFD, rg)
		wr(16'h0401, 1'b0);
		frames(1);
		g = lg;
		frames(128);
		`CHK("ramp_down", g - 8'h01, lg)
		wr(16'h0400, 1'b0);
		frames(1);
		g = lg;
		frames(128);
		`CHK("ramp_up", g + 8'h01, lg)
		frames(300);
		`CHK("restored", 16'hFDFD, {lg, rg})
		end_of_test;
	end
endmodule // tb_sdc_ctrl_regs
